// [rtl/bcpfs_top.sv]
// pin function multiplexer for the bus-control port pins
`timescale 1ns/10ps
`include "bcpfs_params.svh"

module bcpfs_top #(
  parameter int WIDTH = 8
) (
  input  wire logic             CLK_IN,
  input  wire logic             RST_N_IN,
  input  wire logic [2:0]       MODE_IN,
  input  wire logic             WAIT_PIN_ENABLE_IN,
  input  wire logic             BUS_REQUEST_OUT_ENABLE_IN,
  input  wire logic             BUS_RELEASE_ENABLE_IN,
  input  wire logic [2:0]       MEMORY_TYPE_SELECT_IN,
  input  wire logic             BUS_WIDTH_BIT_IN,
  input  wire logic             LOWER_STROBE_SELECT_IN,
  input  wire logic             DRAM_SPACE_SET_IN,
  input  wire logic             PSRAM_SPACE_SET_IN,
  input  wire logic [WIDTH-1:0] PORT_DDR_IN,
  input  wire logic [WIDTH-1:0] PORT_DOUT_IN,
  input  wire logic             BUS_REQUEST_OUT_IN,
  input  wire logic             LOWER_COLUMN_STROBE_IN,
  input  wire logic             BUS_ACK_IN,
  input  wire logic             CHIP_SELECT_ZERO_IN,
  input  wire logic             CHIP_SELECT_ONE_IN,
  input  wire logic             CHIP_SELECT_TWO_IN,
  input  wire logic             CHIP_SELECT_THREE_IN,
  input  wire logic             COLUMN_STROBE_IN,
  input  wire logic             OUTPUT_ENABLE_IN,
  input  wire logic [WIDTH-1:0] PIN_IN,
  output logic      [WIDTH-1:0] PIN_OUT,
  output logic      [WIDTH-1:0] PIN_OE_OUT,
  output logic      [WIDTH-1:0] PORT_DATA_OUT,
  output logic                  WAIT_REQUEST_OUT,
  output logic                  EXTERNAL_BUS_REQUEST_OUT,
  output logic      [3:0]       WAIT_FUNCTION_OUT,
  output logic      [2:0]       STROBE_FUNCTION_OUT
);

  //----------------------------------------------------------
  // mode decode
  //----------------------------------------------------------

  // true in the expanded modes that own the bus-control pins
  function automatic logic is_bus_mode(input logic [2:0] mode);
    is_bus_mode = (mode == `BCPFS_MODE_5)
                  || (mode == `BCPFS_MODE_4);
  endfunction

  //----------------------------------------------------------
  // pin input synchroniser
  //----------------------------------------------------------

  logic [WIDTH-1:0] pin_meta_r;
  logic [WIDTH-1:0] pin_sync_r;
  logic [WIDTH-1:0] pin_meta_nxt;
  logic [WIDTH-1:0] pin_sync_nxt;

  // pins are asynchronous to the clock, so two stages before use
  always_comb
  begin
    pin_meta_nxt = PIN_IN;
    pin_sync_nxt = pin_meta_r;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pin_meta_r <= `BCPFS_RST_PINS;
      pin_sync_r <= `BCPFS_RST_PINS;
    end
    else
    begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
    end
  end

  //----------------------------------------------------------
  // function selection
  //----------------------------------------------------------

  bcpfs_pkg::bcpfs_wait_fn_t   wait_fn_r;
  bcpfs_pkg::bcpfs_wait_fn_t   wait_fn_nxt;
  bcpfs_pkg::bcpfs_strobe_fn_t strobe_fn_r;
  bcpfs_pkg::bcpfs_strobe_fn_t strobe_fn_nxt;
  logic                        release_r;
  logic                        release_nxt;
  logic                        lower_column_strobe_cond;

  // lower strobe wins over the wait and request uses of the pin,
  // since a DRAM with lower strobe cannot give the pin up
  always_comb
  begin
    lower_column_strobe_cond = (MEMORY_TYPE_SELECT_IN >= `BCPFS_MTS_LO)
                && (MEMORY_TYPE_SELECT_IN <= `BCPFS_MTS_HI)
                && !BUS_WIDTH_BIT_IN
                && !LOWER_STROBE_SELECT_IN;
    wait_fn_nxt   = bcpfs_pkg::BCPFS_WFN_IO;
    strobe_fn_nxt = bcpfs_pkg::BCPFS_SFN_IO;
    release_nxt   = 1'h0;
    if (is_bus_mode(MODE_IN))
    begin
      if (lower_column_strobe_cond)
        wait_fn_nxt = bcpfs_pkg::BCPFS_WFN_LOWER_COLUMN_STROBE;
      else if (WAIT_PIN_ENABLE_IN && !BUS_REQUEST_OUT_ENABLE_IN)
        wait_fn_nxt = bcpfs_pkg::BCPFS_WFN_WAIT;
      else if (!WAIT_PIN_ENABLE_IN && BUS_REQUEST_OUT_ENABLE_IN)
        wait_fn_nxt = bcpfs_pkg::BCPFS_WFN_BUS_REQUEST_OUT;
      else
        wait_fn_nxt = bcpfs_pkg::BCPFS_WFN_IO;
      if (DRAM_SPACE_SET_IN)
        strobe_fn_nxt = bcpfs_pkg::BCPFS_SFN_CAS;
      else if (PSRAM_SPACE_SET_IN)
        strobe_fn_nxt = bcpfs_pkg::BCPFS_SFN_OE;
      else
        strobe_fn_nxt = bcpfs_pkg::BCPFS_SFN_IO;
      release_nxt = BUS_RELEASE_ENABLE_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      wait_fn_r   <= bcpfs_pkg::BCPFS_WFN_IO;
      strobe_fn_r <= bcpfs_pkg::BCPFS_SFN_IO;
      release_r   <= `BCPFS_RST_BIT;
    end
    else
    begin
      wait_fn_r   <= wait_fn_nxt;
      strobe_fn_r <= strobe_fn_nxt;
      release_r   <= release_nxt;
    end
  end

  //----------------------------------------------------------
  // pin drive
  //----------------------------------------------------------

  logic [WIDTH-1:0] pin_out_nxt;
  logic [WIDTH-1:0] pin_oe_nxt;
  logic [WIDTH-1:0] pin_out_r;
  logic [WIDTH-1:0] pin_oe_r;
  logic [2:0]       cs_hi;
  logic             bus_mode;

  // default is plain port I/O, then each bus function takes its pin
  always_comb
  begin
    bus_mode    = is_bus_mode(MODE_IN);
    cs_hi       = {CHIP_SELECT_THREE_IN, CHIP_SELECT_TWO_IN, CHIP_SELECT_ONE_IN};
    pin_out_nxt = PORT_DOUT_IN;
    pin_oe_nxt  = PORT_DDR_IN;
    case (wait_fn_r)
      bcpfs_pkg::BCPFS_WFN_IO:
      begin
        pin_out_nxt[`BCPFS_PIN_WAIT] = PORT_DOUT_IN[`BCPFS_PIN_WAIT];
      end
      bcpfs_pkg::BCPFS_WFN_WAIT:
      begin
        pin_oe_nxt[`BCPFS_PIN_WAIT] = 1'h0;
      end
      bcpfs_pkg::BCPFS_WFN_BUS_REQUEST_OUT:
      begin
        pin_out_nxt[`BCPFS_PIN_WAIT] = BUS_REQUEST_OUT_IN;
        pin_oe_nxt[`BCPFS_PIN_WAIT]  = 1'h1;
      end
      bcpfs_pkg::BCPFS_WFN_LOWER_COLUMN_STROBE:
      begin
        pin_out_nxt[`BCPFS_PIN_WAIT] = LOWER_COLUMN_STROBE_IN;
        pin_oe_nxt[`BCPFS_PIN_WAIT]  = 1'h1;
      end
      default:
      begin
        pin_oe_nxt[`BCPFS_PIN_WAIT] = 1'h0;
      end
    endcase
    if (release_r)
    begin
      pin_oe_nxt[`BCPFS_PIN_EXTERNAL_BUS_REQUEST_IN]  = 1'h0;
      pin_out_nxt[`BCPFS_PIN_BACK] = BUS_ACK_IN;
      pin_oe_nxt[`BCPFS_PIN_BACK]  = 1'h1;
    end
    if (bus_mode && PORT_DDR_IN[`BCPFS_PIN_CS0])
      pin_out_nxt[`BCPFS_PIN_CS0] = CHIP_SELECT_ZERO_IN;
    for (int i = 0; i < `BCPFS_NUM_CS_HI; i++)
    begin
      // direction bit 0 leaves the pin an input, 1 drives the select
      if (bus_mode && PORT_DDR_IN[`BCPFS_PIN_CS1 + i])
        pin_out_nxt[`BCPFS_PIN_CS1 + i] = cs_hi[i];
    end
    case (strobe_fn_r)
      bcpfs_pkg::BCPFS_SFN_CAS:
      begin
        pin_out_nxt[`BCPFS_PIN_STROBE] = COLUMN_STROBE_IN;
        pin_oe_nxt[`BCPFS_PIN_STROBE]  = 1'h1;
      end
      bcpfs_pkg::BCPFS_SFN_OE:
      begin
        pin_out_nxt[`BCPFS_PIN_STROBE] = OUTPUT_ENABLE_IN;
        pin_oe_nxt[`BCPFS_PIN_STROBE]  = 1'h1;
      end
      default:
      begin
        pin_out_nxt[`BCPFS_PIN_STROBE] = PORT_DOUT_IN[`BCPFS_PIN_STROBE];
      end
    endcase
  end

  // outputs leave through flip-flops to keep the pads glitch free
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      pin_out_r <= `BCPFS_RST_PINS;
      pin_oe_r  <= `BCPFS_RST_PINS;
    end
    else
    begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  //----------------------------------------------------------
  // inputs returned to the bus controller and the port
  //----------------------------------------------------------

  logic             wait_req_r;
  logic             wait_req_nxt;
  logic             ext_external_bus_request_in_r;
  logic             ext_external_bus_request_in_nxt;
  logic [WIDTH-1:0] port_data_r;
  logic [WIDTH-1:0] port_data_nxt;

  // a function input reads zero unless its pin is assigned to it,
  // so a floating I/O pin never stalls the bus
  always_comb
  begin
    wait_req_nxt  = (wait_fn_r == bcpfs_pkg::BCPFS_WFN_WAIT)
                    && pin_sync_r[`BCPFS_PIN_WAIT];
    ext_external_bus_request_in_nxt  = release_r && pin_sync_r[`BCPFS_PIN_EXTERNAL_BUS_REQUEST_IN];
    port_data_nxt = pin_sync_r;
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      wait_req_r  <= `BCPFS_RST_BIT;
      ext_external_bus_request_in_r  <= `BCPFS_RST_BIT;
      port_data_r <= `BCPFS_RST_PINS;
    end
    else
    begin
      wait_req_r  <= wait_req_nxt;
      ext_external_bus_request_in_r  <= ext_external_bus_request_in_nxt;
      port_data_r <= port_data_nxt;
    end
  end

  //----------------------------------------------------------
  // output wiring
  //----------------------------------------------------------

  always_comb
  begin
    PIN_OUT                  = pin_out_r;
    PIN_OE_OUT               = pin_oe_r;
    PORT_DATA_OUT            = port_data_r;
    WAIT_REQUEST_OUT         = wait_req_r;
    EXTERNAL_BUS_REQUEST_OUT = ext_external_bus_request_in_r;
    WAIT_FUNCTION_OUT        = wait_fn_r;
    STROBE_FUNCTION_OUT      = strobe_fn_r;
  end

endmodule // bcpfs_top

// [include/bcpfs_params.svh]
// constants of the bus-control pin function select block
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef BCPFS_PARAMS_SVH
`define BCPFS_PARAMS_SVH

// operating mode codes
`define BCPFS_MODE_4        3'h4
`define BCPFS_MODE_5        3'h5

// memory type select range that gives the lower column strobe
`define BCPFS_MTS_LO        3'h1
`define BCPFS_MTS_HI        3'h3

// pin positions within the port
`define BCPFS_PIN_WAIT      3
`define BCPFS_PIN_EXTERNAL_BUS_REQUEST_IN      2
`define BCPFS_PIN_BACK      1
`define BCPFS_PIN_CS0       0
`define BCPFS_PIN_CS1       4
`define BCPFS_PIN_STROBE    7
`define BCPFS_NUM_CS_HI     3

// reset values
`define BCPFS_RST_PINS      8'h00
`define BCPFS_RST_BIT       1'h0

`endif

// [include/bcpfs_pkg.sv]
// types of the bus-control pin function select block
package bcpfs_pkg;

  // function of the multiplexed wait pin, one-hot
  typedef enum logic [3:0]
  {
    BCPFS_WFN_IO    = 4'h1,
    BCPFS_WFN_WAIT  = 4'h2,
    BCPFS_WFN_BUS_REQUEST_OUT = 4'h4,
    BCPFS_WFN_LOWER_COLUMN_STROBE  = 4'h8
  } bcpfs_wait_fn_t;

  // function of the column strobe pin, one-hot
  typedef enum logic [2:0]
  {
    BCPFS_SFN_IO  = 3'h1,
    BCPFS_SFN_CAS = 3'h2,
    BCPFS_SFN_OE  = 3'h4
  } bcpfs_strobe_fn_t;

endpackage

// [verification/bcpfs_asserts.sv]
// checker of the pin function selection at the top ports
`timescale 1ns/10ps
module bcpfs_asserts (
  input wire logic       CLK_IN,
  input wire logic       RST_N_IN,
  input wire logic [2:0] MODE_IN,
  input wire logic       WAIT_PIN_ENABLE_IN,
  input wire logic       BUS_REQUEST_OUT_ENABLE_IN,
  input wire logic       BUS_RELEASE_ENABLE_IN,
  input wire logic [2:0] MEMORY_TYPE_SELECT_IN,
  input wire logic       BUS_WIDTH_BIT_IN,
  input wire logic       LOWER_STROBE_SELECT_IN,
  input wire logic       DRAM_SPACE_SET_IN,
  input wire logic       PSRAM_SPACE_SET_IN,
  input wire logic [7:0] PORT_DDR_IN,
  input wire logic       BUS_ACK_IN,
  input wire logic       CHIP_SELECT_ONE_IN,
  input wire logic [7:0] PIN_OUT,
  input wire logic [7:0] PIN_OE_OUT,
  input wire logic [3:0] WAIT_FUNCTION_OUT,
  input wire logic [2:0] STROBE_FUNCTION_OUT
);
  logic bus;
  logic low;
  logic we;
  logic be;
  // modes four and five select alike
  assign bus = (MODE_IN == 3'h4) || (MODE_IN == 3'h5);
  assign low = bus && (MEMORY_TYPE_SELECT_IN inside {[3'h1:3'h3]}) && !BUS_WIDTH_BIT_IN
               && !LOWER_STROBE_SELECT_IN;
  assign we = WAIT_PIN_ENABLE_IN;
  assign be = BUS_REQUEST_OUT_ENABLE_IN;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  a_wait_io: assert property (bus && !low && (we == be) |=> WAIT_FUNCTION_OUT == 4'h1)
    else $error("wait pin not plain io");
  a_wait_input: assert property (bus && !low && we && !be |=> WAIT_FUNCTION_OUT == 4'h2)
    else $error("wait pin not wait input");
  a_external_bus_request_in_out: assert property (bus && !low && !we && be |=> WAIT_FUNCTION_OUT == 4'h4)
    else $error("wait pin not bus request");
  a_low_strobe: assert property (low |=> WAIT_FUNCTION_OUT == 4'h8)
    else $error("wait pin not lower strobe");
  a_release_pair: assert property (bus && BUS_RELEASE_ENABLE_IN [*2] |=>
    PIN_OE_OUT[2:1] == 2'h1 && PIN_OUT[1] == $past(BUS_ACK_IN)) else $error("release pair wrong");
  a_cs_drive: assert property (bus && PORT_DDR_IN[4] [*2] |=>
    PIN_OE_OUT[4] && PIN_OUT[4] == $past(CHIP_SELECT_ONE_IN)) else $error("select not driven");
  a_cs_input: assert property (bus && !PORT_DDR_IN[4] [*2] |=> !PIN_OE_OUT[4])
    else $error("select input driven");
  a_strobe_fn: assert property (bus |=> STROBE_FUNCTION_OUT == ($past(DRAM_SPACE_SET_IN) ?
    3'h2 : ($past(PSRAM_SPACE_SET_IN) ? 3'h4 : 3'h1))) else $error("strobe function wrong");
  a_idle_modes: assert property (!bus |=>
    WAIT_FUNCTION_OUT == 4'h1 && STROBE_FUNCTION_OUT == 3'h1) else $error("non bus mode not io");
endmodule // bcpfs_asserts
bind bcpfs_top bcpfs_asserts u_chk (.CLK_IN, .RST_N_IN, .MODE_IN, .WAIT_PIN_ENABLE_IN,
  .BUS_REQUEST_OUT_ENABLE_IN, .BUS_RELEASE_ENABLE_IN, .MEMORY_TYPE_SELECT_IN, .BUS_WIDTH_BIT_IN,
  .LOWER_STROBE_SELECT_IN, .DRAM_SPACE_SET_IN, .PSRAM_SPACE_SET_IN, .PORT_DDR_IN, .BUS_ACK_IN,
  .CHIP_SELECT_ONE_IN, .PIN_OUT, .PIN_OE_OUT, .WAIT_FUNCTION_OUT, .STROBE_FUNCTION_OUT);

// [verification/bcpfs_far_model.sv]
// external memory and bus master seen at the pads
`timescale 1ns/10ps
module bcpfs_far_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] pin_out_in,
  input  wire logic [7:0] pin_oe_in,
  input  wire logic       wait_in,
  input  wire logic       external_bus_request_in_in,
  output logic      [7:0] pad_out
);
  logic [7:0] ring_r = 8'h55;
  // released pads wander so a stale level never passes for an answer
  always_ff @(posedge clk_in) ring_r <= ~ring_r;
  always_comb
  begin
    pad_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ring_r);
    if (!pin_oe_in[3]) pad_out[3] = wait_in; // memory asks for wait
    if (!pin_oe_in[2]) pad_out[2] = external_bus_request_in_in; // master asks for the bus
  end
endmodule // bcpfs_far_model

// [verification/bcpfs_tb.sv]
// self-checking bench of the pin function selection
`timescale 1ns/10ps
module bus_control_pin_function_select_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, be = 1'b0, rel = 1'b0, bw = 1'b0, lss = 1'b0;
  logic dram = 1'b0, psram = 1'b0, wlev = 1'b0, blev = 1'b0;
  // function values from the bus controller, varied so each pass-through is seen
  logic bus_request_out = 1'b1, lower_column_strobe = 1'b0, back = 1'b1, cas_fn = 1'b1, oe_fn = 1'b0;
  logic [3:0] cs = 4'h5;
  logic [2:0] mode = 3'h5, mts = 3'h0;
  logic [7:0] ddr = 8'h00, pad, po, poe, pdo;
  logic       wreq, ereq;
  logic [3:0] wfn;
  logic [2:0] sfn;
  int         n_fail = 0, n_checks = 0;
  always #25 clk = ~clk;
  bcpfs_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .MODE_IN(mode), .WAIT_PIN_ENABLE_IN(we),
    .BUS_REQUEST_OUT_ENABLE_IN(be), .BUS_RELEASE_ENABLE_IN(rel), .MEMORY_TYPE_SELECT_IN(mts),
    .BUS_WIDTH_BIT_IN(bw), .LOWER_STROBE_SELECT_IN(lss), .DRAM_SPACE_SET_IN(dram),
    .PSRAM_SPACE_SET_IN(psram), .PORT_DDR_IN(ddr), .PORT_DOUT_IN(8'h5A),
    .BUS_REQUEST_OUT_IN(bus_request_out), .LOWER_COLUMN_STROBE_IN(lower_column_strobe), .BUS_ACK_IN(back),
    .CHIP_SELECT_ZERO_IN(cs[0]), .CHIP_SELECT_ONE_IN(cs[1]), .CHIP_SELECT_TWO_IN(cs[2]),
    .CHIP_SELECT_THREE_IN(cs[3]), .COLUMN_STROBE_IN(cas_fn), .OUTPUT_ENABLE_IN(oe_fn),
    .PIN_IN(pad), .PIN_OUT(po),
    .PIN_OE_OUT(poe), .PORT_DATA_OUT(pdo), .WAIT_REQUEST_OUT(wreq),
    .EXTERNAL_BUS_REQUEST_OUT(ereq), .WAIT_FUNCTION_OUT(wfn), .STROBE_FUNCTION_OUT(sfn));
  bcpfs_far_model far (.clk_in(clk), .pin_out_in(po), .pin_oe_in(poe), .wait_in(wlev),
    .external_bus_request_in_in(blev), .pad_out(pad));
  //--------------------------------
  // shared helpers
  //--------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin $display("Error %0t got %h exp %h", $time, g, e); n_fail++; end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  //--------------------------------
  // scenarios
  //--------------------------------
  task automatic t_reset();
    rst_n = 1'b0;
    step(6);
    chk(8'(wfn), 8'h01); chk(8'(sfn), 8'h01); chk(poe, 8'h00);
    rst_n = 1'b1;
    step(1);
  endtask
  task automatic t_wait();
    logic [3:0] ex [4] = '{4'h1, 4'h2, 4'h4, 4'h1};
    for (int m = 4; m < 6; m++)
      for (int i = 0; i < 4; i++)
      begin
        mode = 3'(m); we = i[0]; be = i[1]; bus_request_out = (m == 5);
        step(3);
        chk(8'(wfn), 8'(ex[i]));
        chk(8'(poe[3]), 8'(i == 2));
        if (i == 2) chk(8'(po[3]), 8'(m == 5));
      end
    we = 1'b1; be = 1'b0;
    // types around the strobe range, then width and select each blocking it
    for (int t = 0; t < 7; t++)
    begin
      mts = (t < 5) ? 3'(t) : 3'h2; bw = (t == 5); lss = (t == 6); lower_column_strobe = t[0];
      step(3);
      chk(8'(wfn), (t >= 1 && t <= 3) ? 8'h08 : 8'h02);
      chk(8'(poe[3]), 8'(t >= 1 && t <= 3));
      if (t >= 1 && t <= 3) chk(8'(po[3]), 8'(t[0]));
    end
    mts = 3'h0; bw = 1'b0; lss = 1'b0;
  endtask
  task automatic t_sync();
    we = 1'b1; wlev = 1'b1;
    step(5);
    chk(8'(wreq), 8'h01);
    wlev = 1'b0;
    step(4);
    chk(8'(wreq), 8'h00);
    we = 1'b0; wlev = 1'b1;
    step(5);
    chk(8'(wreq), 8'h00);
    wlev = 1'b0;
  endtask
  task automatic t_release();
    rel = 1'b1; blev = 1'b1; back = 1'b1;
    step(5);
    chk(8'(ereq), 8'h01); chk(8'(poe[2:1]), 8'h01); chk(8'(po[1]), 8'h01);
    back = 1'b0;
    step(2);
    chk(8'(po[1]), 8'h00);
    rel = 1'b0;
    step(5);
    chk(8'(ereq), 8'h00); chk(8'(poe[2:1]), 8'h00);
    blev = 1'b0;
  endtask
  task automatic t_cs();
    ddr = 8'h71; cs = 4'h5;
    step(3);
    chk(poe & 8'h71, 8'h71); chk(po & 8'h71, 8'h21);
    // swap every select so a crossed wire shows, then read the pads back
    cs = 4'hA;
    step(4);
    chk(po & 8'h71, 8'h50); chk(pdo & 8'h71, 8'h50);
    ddr = 8'h00;
    step(3);
    chk(poe & 8'h71, 8'h00);
  endtask
  task automatic t_strobe();
    logic [2:0] ex [4] = '{3'h1, 3'h2, 3'h4, 3'h2};
    for (int i = 0; i < 4; i++)
    begin
      dram = i[0]; psram = i[1]; cas_fn = ~i[1]; oe_fn = i[1];
      step(3);
      chk(8'(sfn), 8'(ex[i])); chk(8'(poe[7]), 8'(i != 0));
      if (i != 0) chk(8'(po[7]), 8'(dram ? cas_fn : oe_fn));
    end
    // a non-bus mode ignores every control
    mode = 3'h7; we = 1'b1; rel = 1'b1;
    step(3);
    chk(8'(wfn), 8'h01); chk(8'(sfn), 8'h01);
    mode = 3'h5; we = 1'b0; rel = 1'b0; dram = 1'b0; psram = 1'b0;
  endtask
  initial
  begin
    t_reset();
    t_wait();
    t_sync();
    t_release();
    t_cs();
    t_strobe();
    t_reset();
    t_cs();
    conclude();
  end
endmodule // bus_control_pin_function_select_tb_top
